// file: rtl/gxw_regs.svh
`ifndef GXW_REGS_SVH
`define GXW_REGS_SVH

// Register byte addresses
`define GXW_ADR_PENDING 32'h4000A814
`define GXW_ADR_CFG_A 32'h4000A860
`define GXW_ADR_CFG_B 32'h4000A864
`define GXW_ADR_CFG_C 32'h4000A868
`define GXW_ADR_CFG_D 32'h4000A86C
`define GXW_ADR_DBGCFG 32'h4000BC00
`define GXW_ADR_DBGSTAT 32'h4000BC04
`define GXW_ADR_C_SEL 32'h4000BC14
`define GXW_ADR_D_SEL 32'h4000BC18
`define GXW_ADR_WAKEFILT 32'h4000BC1C
`define GXW_ADR_IRQ_STATUS 32'h4000BC40
`define GXW_ADR_IRQ_ENABLE 32'h4000BC44
`define GXW_ADR_IRQ_CLEAR 32'h4000BC48

// Field positions
`define GXW_CFG_FILT_BIT 8
`define GXW_CFG_MODE_HI 7
`define GXW_CFG_MODE_LO 5
`define GXW_SEL_HI 4
`define GXW_DBG_DIS_BIT 5
`define GXW_DBG_EXTREG_BIT 4
`define GXW_DBG_RSVD_BIT 3
`define GXW_STAT_BOOT_BIT 3
`define GXW_STAT_FORCED_BIT 1
`define GXW_STAT_SWEN_BIT 0
`define GXW_WF_IRQ_D_BIT 3
`define GXW_WF_RX_BIT 1
`define GXW_WF_PORT_BIT 0
`define GXW_PENDING_MASK 4'hD

// Reset values
`define GXW_C_SEL_RST 5'h0F
`define GXW_D_SEL_RST 5'h10
`define GXW_EXTREG_RST 1'b1

// Filter length, channel count and RX channel index
`define GXW_FILT_LEN_DEF 3'h4
`define GXW_NCH 28
`define GXW_RX_CH 14

`endif

// file: rtl/gxw_pkg.sv
package gxw_pkg;

  typedef enum logic [2:0] {
    GXW_MODE_OFF,
    GXW_MODE_RISE,
    GXW_MODE_FALL,
    GXW_MODE_BOTH,
    GXW_MODE_HIGH,
    GXW_MODE_LOW
  } gxw_mode_type;

  typedef struct packed {
    logic [3:0][2:0] mode;
    logic [3:0] filt_en;
    logic [4:0] c_sel;
    logic [4:0] d_sel;
    logic [2:0] wake_filt;
    logic dbg_dis;
    logic ext_reg;
    logic dbg_rsvd;
    logic [3:0] pending;
    logic [3:0] irq_en;
    logic [3:0] prev;
    logic [27:0] filt;
    logic [27:0][2:0] cnt;
    logic ack;
    logic [31:0] rdata;
    logic boot;
    logic rst_done;
    logic forced;
    logic swen;
    logic dbg_ovr;
    logic [23:0] wake_port;
    logic wake_rx;
    logic wake_d;
  } gxw_state_type;

endpackage : gxw_pkg

// file: rtl/gxw_irq_wake.sv
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "gxw_regs.svh"

module gxw_irq_wake #(
  parameter logic [2:0] FILT_LEN = `GXW_FILT_LEN_DEF
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic EXT_INT_A,
  input wire logic EXT_INT_B,
  input wire logic [7:0] PORT_A,
  input wire logic [7:0] PORT_B,
  input wire logic [7:0] PORT_C,
  input wire logic [23:0] PORT_WAKE_EN,
  input wire logic BOOT_SELECT_PIN_N,
  input wire logic DEBUGGER_FORCED_ACTIVE,
  input wire logic SERIAL_WIRE_ENABLED,
  output logic IRQ,
  output logic DEBUG_OVERRIDE_EN,
  output logic REG_EN_OVERRIDE,
  output logic [23:0] WAKE_PORT,
  output logic WAKE_SERIAL_RX,
  output logic WAKE_IRQ_D
);

  gxw_pkg::gxw_state_type st_ff;
  gxw_pkg::gxw_state_type nxt_st;
  logic [27:0] raw;
  logic [3:0] src;
  logic req;
  logic wr;

  // Pin selector for interrupts C and D
  function automatic logic pin_sel(input logic [4:0] code, input logic [7:0] pa,
                                   input logic [7:0] pb, input logic [7:0] pc);
    logic r;
    r = 1'b0;
    if (code == 5'h04 || code == 5'h05 || code == 5'h07) begin
      r = pa[code[2:0]];
    end else if (code >= 5'h08 && code <= 5'h0C) begin
      r = pb[code[2:0]];
    end else if (code >= 5'h10 && code <= 5'h17) begin
      r = pc[code[2:0]];
    end
    return r;
  endfunction : pin_sel

  // Trigger decode per mode
  function automatic logic trig(input logic [2:0] m, input logic cur, input logic prv);
    logic r;
    r = 1'b0;
    case (gxw_pkg::gxw_mode_type'(m))
      gxw_pkg::GXW_MODE_RISE: r = cur & ~prv;
      gxw_pkg::GXW_MODE_FALL: r = ~cur & prv;
      gxw_pkg::GXW_MODE_BOTH: r = cur ^ prv;
      gxw_pkg::GXW_MODE_HIGH: r = cur;
      gxw_pkg::GXW_MODE_LOW: r = ~cur;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : trig

  always_comb begin
    raw = {PORT_C, PORT_B, PORT_A,
           pin_sel(st_ff.d_sel, PORT_A, PORT_B, PORT_C),
           pin_sel(st_ff.c_sel, PORT_A, PORT_B, PORT_C),
           EXT_INT_B, EXT_INT_A};
    for (int k = 0; k < 4; k++) begin
      src[k] = st_ff.filt_en[k] ? st_ff.filt[k] : raw[k];
    end
  end

  assign req = WB_CYC_I & WB_STB_I & ~st_ff.ack;
  assign wr = req & WB_WE_I;

  always_comb begin
    logic [3:0] set;
    logic [3:0] clr;
    logic [31:0] rd;
    set = 4'h0;
    clr = 4'h0;
    rd = 32'h0000_0000;
    nxt_st = st_ff;
    if (!RST_N) begin
      nxt_st = '0;
      nxt_st.c_sel = `GXW_C_SEL_RST;
      nxt_st.d_sel = `GXW_D_SEL_RST;
      nxt_st.ext_reg = `GXW_EXTREG_RST;
    end else if (CE) begin
      // Input filters
      for (int k = 0; k < `GXW_NCH; k++) begin
        if (raw[k] == st_ff.filt[k]) begin
          nxt_st.cnt[k] = 3'h0;
        end else if (st_ff.cnt[k] == FILT_LEN - 3'h1) begin
          nxt_st.filt[k] = raw[k];
          nxt_st.cnt[k] = 3'h0;
        end else begin
          nxt_st.cnt[k] = st_ff.cnt[k] + 3'h1;
        end
      end
      // Trigger detection
      for (int k = 0; k < 4; k++) begin
        set[k] = trig(st_ff.mode[k], src[k], st_ff.prev[k]);
      end
      nxt_st.prev = src;
      // Wake sources
      for (int j = 0; j < 24; j++) begin
        nxt_st.wake_port[j] = PORT_WAKE_EN[j] &
          (st_ff.wake_filt[0] ? st_ff.filt[4 + j] : raw[4 + j]);
      end
      nxt_st.wake_rx = st_ff.wake_filt[1] ? st_ff.filt[`GXW_RX_CH] : raw[`GXW_RX_CH];
      nxt_st.wake_d = st_ff.wake_filt[2] ? st_ff.filt[3] : raw[3];
      // Debug status and override
      nxt_st.forced = DEBUGGER_FORCED_ACTIVE;
      nxt_st.swen = SERIAL_WIRE_ENABLED;
      nxt_st.dbg_ovr = ~st_ff.dbg_dis | SERIAL_WIRE_ENABLED | DEBUGGER_FORCED_ACTIVE;
      if (!st_ff.rst_done) begin
        nxt_st.boot = ~BOOT_SELECT_PIN_N;
        nxt_st.rst_done = 1'b1;
      end
      // Bus access
      nxt_st.ack = req;
      if (wr) begin
        case (WB_ADR_I)
          `GXW_ADR_PENDING: begin
            if (WB_SEL_I[0]) begin
              clr = WB_DAT_I[3:0] & `GXW_PENDING_MASK;
            end
          end
          `GXW_ADR_CFG_A, `GXW_ADR_CFG_B, `GXW_ADR_CFG_C, `GXW_ADR_CFG_D: begin
            if (WB_SEL_I[1]) begin
              nxt_st.filt_en[WB_ADR_I[3:2]] = WB_DAT_I[`GXW_CFG_FILT_BIT];
            end
            if (WB_SEL_I[0]) begin
              nxt_st.mode[WB_ADR_I[3:2]] = WB_DAT_I[`GXW_CFG_MODE_HI:`GXW_CFG_MODE_LO];
            end
          end
          `GXW_ADR_DBGCFG: begin
            if (WB_SEL_I[0]) begin
              nxt_st.dbg_dis = WB_DAT_I[`GXW_DBG_DIS_BIT];
              nxt_st.ext_reg = WB_DAT_I[`GXW_DBG_EXTREG_BIT];
              nxt_st.dbg_rsvd = WB_DAT_I[`GXW_DBG_RSVD_BIT];
            end
          end
          `GXW_ADR_C_SEL: begin
            if (WB_SEL_I[0]) begin
              nxt_st.c_sel = WB_DAT_I[`GXW_SEL_HI:0];
            end
          end
          `GXW_ADR_D_SEL: begin
            if (WB_SEL_I[0]) begin
              nxt_st.d_sel = WB_DAT_I[`GXW_SEL_HI:0];
            end
          end
          `GXW_ADR_WAKEFILT: begin
            if (WB_SEL_I[0]) begin
              nxt_st.wake_filt = {WB_DAT_I[`GXW_WF_IRQ_D_BIT], WB_DAT_I[`GXW_WF_RX_BIT],
                                  WB_DAT_I[`GXW_WF_PORT_BIT]};
            end
          end
          `GXW_ADR_IRQ_ENABLE: begin
            if (WB_SEL_I[0]) begin
              nxt_st.irq_en = WB_DAT_I[3:0];
            end
          end
          `GXW_ADR_IRQ_CLEAR: begin
            if (WB_SEL_I[0]) begin
              clr = WB_DAT_I[3:0];
            end
          end
          default: clr = 4'h0;
        endcase
      end
      // Set wins over clear
      nxt_st.pending = (st_ff.pending & ~clr) | set;
      if (req && !WB_WE_I) begin
        case (WB_ADR_I)
          `GXW_ADR_PENDING: rd = {28'h0, st_ff.pending & `GXW_PENDING_MASK};
          `GXW_ADR_CFG_A, `GXW_ADR_CFG_B, `GXW_ADR_CFG_C, `GXW_ADR_CFG_D: begin
            rd = {23'h0, st_ff.filt_en[WB_ADR_I[3:2]], st_ff.mode[WB_ADR_I[3:2]], 5'h00};
          end
          `GXW_ADR_DBGCFG: rd = {26'h0, st_ff.dbg_dis, st_ff.ext_reg, st_ff.dbg_rsvd, 3'h0};
          `GXW_ADR_DBGSTAT: rd = {28'h0, st_ff.boot, 1'b0, st_ff.forced, st_ff.swen};
          `GXW_ADR_C_SEL: rd = {27'h0, st_ff.c_sel};
          `GXW_ADR_D_SEL: rd = {27'h0, st_ff.d_sel};
          `GXW_ADR_WAKEFILT: begin
            rd = {28'h0, st_ff.wake_filt[2], 1'b0, st_ff.wake_filt[1], st_ff.wake_filt[0]};
          end
          `GXW_ADR_IRQ_STATUS: rd = {28'h0, st_ff.pending};
          `GXW_ADR_IRQ_ENABLE: rd = {28'h0, st_ff.irq_en};
          default: rd = 32'h0000_0000;
        endcase
        nxt_st.rdata = rd;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    st_ff <= nxt_st;
  end

  assign WB_DAT_O = st_ff.rdata;
  assign WB_ACK_O = st_ff.ack;
  assign IRQ = |(st_ff.pending & st_ff.irq_en);
  assign DEBUG_OVERRIDE_EN = st_ff.dbg_ovr;
  assign REG_EN_OVERRIDE = st_ff.ext_reg;
  assign WAKE_PORT = st_ff.wake_port;
  assign WAKE_SERIAL_RX = st_ff.wake_rx;
  assign WAKE_IRQ_D = st_ff.wake_d;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  AST_RISE_A: assert property (
    CE && st_ff.mode[0] == 3'h1 && src[0] && !st_ff.prev[0] |=> st_ff.pending[0])
    else $error("Rising edge did not set pending A");

  AST_OFF_A: assert property (
    CE && st_ff.mode[0] == 3'h0 && !st_ff.pending[0] |=> !st_ff.pending[0])
    else $error("Disabled interrupt A became pending");

  AST_LOW_B: assert property (
    CE && st_ff.mode[1] == 3'h5 && !src[1] |=> st_ff.pending[1])
    else $error("Low level did not hold pending B");

  AST_W1C_A: assert property (
    CE && wr && WB_ADR_I == `GXW_ADR_PENDING && WB_SEL_I[0] && WB_DAT_I[0]
      && st_ff.mode[0] == 3'h0 |=> !st_ff.pending[0] ##1 WB_ACK_O == 1'b0)
    else $error("Write one did not clear pending A");

  AST_IRQ_OUT: assert property (
    CE && st_ff.mode[2] == 3'h4 && src[2] && st_ff.irq_en[2] |=> IRQ)
    else $error("Enabled high level on C did not raise interrupt");

  AST_SEL_RSVD: assert property (
    st_ff.c_sel >= 5'h18 || st_ff.c_sel < 5'h04 |-> raw[2] == 1'b0)
    else $error("Reserved selector routed a pin");

  AST_FILT_HOLD: assert property (
    CE && st_ff.filt_en[0] == 1'b1 && st_ff.filt[0] != raw[0] && st_ff.cnt[0] == 3'h0
      |=> st_ff.filt[0] != $past(raw[0]) || FILT_LEN < 3'h2)
    else $error("Filter accepted a single sample");

  AST_DBG_DIS: assert property (
    CE && st_ff.dbg_dis && !SERIAL_WIRE_ENABLED && !DEBUGGER_FORCED_ACTIVE
      |=> !DEBUG_OVERRIDE_EN)
    else $error("Debug override not disabled");

  AST_BOOT: assert property (
    $rose(st_ff.rst_done) |-> st_ff.boot == !$past(BOOT_SELECT_PIN_N))
    else $error("Boot pin not sampled at reset release");

  AST_WAKE_RAW: assert property (
    CE && !st_ff.wake_filt[0] |=> WAKE_PORT == $past(PORT_WAKE_EN & {PORT_C, PORT_B, PORT_A}))
    else $error("Unfiltered port wake mismatch");

endmodule : gxw_irq_wake

`default_nettype wire

// file: verif/gxw_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module gxw_pin_model (
  input wire logic clk,
  output logic ext_a,
  output logic [23:0] pins,
  output logic boot_n,
  output logic forced,
  output logic swen
);
  // Boot pin held asserted through reset
  initial begin
    ext_a = 1'b0;
    pins = 24'h000000;
    boot_n = 1'b0;
    forced = 1'b0;
    swen = 1'b0;
  end
  // Pins change just after an edge, then hold n cycles
  task automatic put(input logic a, input logic [23:0] p, input int n);
    @(posedge clk);
    ext_a <= a;
    pins <= p;
    repeat (n) @(posedge clk);
  endtask : put
  // Debugger cable and serial-wire status levels
  task automatic stat(input logic f, input logic s);
    @(posedge clk);
    forced <= f;
    swen <= s;
  endtask : stat
endmodule : gxw_pin_model
`default_nettype wire

// file: verif/gxw_irq_wake_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "gxw_regs.svh"
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("Error %s expected %h seen %h", n, e, g); \
  end \
end
module gxw_irq_wake_tb_top;
  logic clk, rst_n, cyc, we, ack, irq, dbg_ovr, reg_ovr, wake_rx, ea, boot_n, forced, swen;
  logic wake_d;
  logic [31:0] adr, dat, rdat, exp_v;
  logic [23:0] pins, wake_p, wen, p;
  logic [31:0] exp_q[$];
  int err_count, num_checks;
  logic e0, e1, e2, e3;
  gxw_irq_wake #(.FILT_LEN(3'h3)) u_gxw_irq_wake (.REF_CLK(clk), .RST_N(rst_n), .CE(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .EXT_INT_A(ea), .EXT_INT_B(1'b0),
    .PORT_A(pins[7:0]), .PORT_B(pins[15:8]), .PORT_C(pins[23:16]), .PORT_WAKE_EN(wen),
    .BOOT_SELECT_PIN_N(boot_n), .DEBUGGER_FORCED_ACTIVE(forced), .SERIAL_WIRE_ENABLED(swen),
    .IRQ(irq), .DEBUG_OVERRIDE_EN(dbg_ovr), .REG_EN_OVERRIDE(reg_ovr), .WAKE_PORT(wake_p),
    .WAKE_SERIAL_RX(wake_rx), .WAKE_IRQ_D(wake_d));
  gxw_pin_model u_gxw_pin_model (.clk(clk), .ext_a(ea), .pins(pins), .boot_n(boot_n),
    .forced(forced), .swen(swen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // Classic single cycle; a read notes its expected data
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
  endtask : bus
  // Read data checked at the acknowledging edge
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, rdat)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    adr = 32'h00000000;
    dat = 32'h00000000;
    wen = 24'h000000;
    void'($urandom(31));
    wen = 24'($urandom);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, `GXW_ADR_DBGCFG, 32'h00000010);
    bus(0, `GXW_ADR_C_SEL, 32'h0000000F);
    bus(0, `GXW_ADR_D_SEL, 32'h00000010);
    bus(0, `GXW_ADR_CFG_B, 32'h00000000);
    bus(0, 32'h4000BC20, 32'h00000000);
    `CHK("reg_ovr", 1'b1, reg_ovr)
    `CHK("dbg_ovr", 1'b1, dbg_ovr)
    // Every trigger mode on interrupt A, reserved ones included
    bus(1, `GXW_ADR_IRQ_ENABLE, 32'h00000001);
    for (int m = 0; m < 8; m++) begin
      e0 = (m == 5);
      e1 = m inside {1, 3, 4, 5};
      e2 = (m == 4);
      e3 = e2 || m inside {2, 3, 5};
      u_gxw_pin_model.put(1'b0, 24'h000000, 5);
      bus(1, `GXW_ADR_CFG_A, (32'(m) << 5) | (32'(m & 1) << 8));
      bus(0, `GXW_ADR_CFG_A, (32'(m) << 5) | (32'(m & 1) << 8));
      bus(1, `GXW_ADR_PENDING, 32'h00000001);
      bus(0, `GXW_ADR_PENDING, {31'h0, e0});
      `CHK("irq", e0, irq)
      u_gxw_pin_model.put(1'b1, 24'h000000, 5);
      bus(1, `GXW_ADR_PENDING, 32'h00000002);
      bus(0, `GXW_ADR_PENDING, {31'h0, e1});
      bus(1, `GXW_ADR_PENDING, 32'h00000001);
      bus(0, `GXW_ADR_PENDING, {31'h0, e2});
      `CHK("irq", e2, irq)
      u_gxw_pin_model.put(1'b0, 24'h000000, 5);
      bus(0, `GXW_ADR_PENDING, {31'h0, e3});
    end
    // Every selector code on interrupt C, level high
    bus(1, `GXW_ADR_CFG_C, 32'h00000080);
    for (int c = 0; c < 32; c++) begin
      p = 24'($urandom);
      u_gxw_pin_model.put(1'b0, p, 1);
      bus(1, `GXW_ADR_C_SEL, 32'(c));
      repeat (4) @(posedge clk);
      bus(1, `GXW_ADR_PENDING, 32'h00000004);
      e0 = (c inside {4, 5, 7, [8:12], [16:23]}) && p[c];
      bus(0, `GXW_ADR_PENDING, {29'h0, e0, 2'b00});
    end
    bus(1, `GXW_ADR_C_SEL, 32'h00000017);
    u_gxw_pin_model.put(1'b0, 24'hFF0000, 5);
    `CHK("irq", 1'b0, irq)
    bus(1, `GXW_ADR_IRQ_ENABLE, 32'h00000004);
    `CHK("irq", 1'b1, irq)
    bus(1, `GXW_ADR_CFG_C, 32'h00000000);
    bus(1, `GXW_ADR_IRQ_CLEAR, 32'h00000004);
    bus(0, `GXW_ADR_IRQ_STATUS, 32'h00000000);
    `CHK("irq", 1'b0, irq)
    // Interrupt B active low, seen only in IRQ status register, not in pending
    bus(1, `GXW_ADR_CFG_B, 32'h000000A0);
    bus(0, `GXW_ADR_IRQ_STATUS, 32'h00000002);
    bus(0, `GXW_ADR_PENDING, 32'h00000000);
    bus(1, `GXW_ADR_CFG_B, 32'h00000000);
    bus(1, `GXW_ADR_IRQ_CLEAR, 32'h00000002);
    // Debug overrides, reserved bit written back as read
    bus(1, `GXW_ADR_DBGCFG, 32'h00000020);
    bus(0, `GXW_ADR_DBGCFG, 32'h00000020);
    bus(0, `GXW_ADR_DBGSTAT, 32'h00000008);
    `CHK("reg_ovr", 1'b0, reg_ovr)
    `CHK("dbg_ovr", 1'b0, dbg_ovr)
    u_gxw_pin_model.stat(1'b1, 1'b1);
    bus(0, `GXW_ADR_DBGSTAT, 32'h0000000B);
    `CHK("dbg_ovr", 1'b1, dbg_ovr)
    // Wake sources, plain then filtered
    p = 24'($urandom);
    bus(1, `GXW_ADR_WAKEFILT, {8'h00, p});
    bus(0, `GXW_ADR_WAKEFILT, {28'h0, p[3:0] & 4'hB});
    bus(1, `GXW_ADR_WAKEFILT, 32'h00000000);
    u_gxw_pin_model.put(1'b0, p, 5);
    `CHK("wake_p", p & wen, wake_p)
    `CHK("wake_rx", p[10], wake_rx)
    `CHK("wake_d", p[16], wake_d)
    bus(1, `GXW_ADR_WAKEFILT, 32'h0000000B);
    u_gxw_pin_model.put(1'b0, ~p, 1);
    u_gxw_pin_model.put(1'b0, p, 6);
    `CHK("wake_p", p & wen, wake_p)
    `CHK("wake_rx", p[10], wake_rx)
    `CHK("wake_d", p[16], wake_d)
    u_gxw_pin_model.put(1'b0, ~p, 6);
    `CHK("wake_p", ~p & wen, wake_p)
    `CHK("wake_rx", ~p[10], wake_rx)
    `CHK("wake_d", ~p[16], wake_d)
    // Mid-run reset restores debug configuration
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, `GXW_ADR_DBGCFG, 32'h00000010);
    `CHK("reg_ovr", 1'b1, reg_ovr)
    `CHK("dbg_ovr", 1'b1, dbg_ovr)
    finish_test();
  end
endmodule : gxw_irq_wake_tb_top
`default_nettype wire
